//--- verilog/aps_pkg.sv
package aps_pkg;
    // Clock and timing
    localparam int CLK_HZ = 50_000_000;
    localparam int START_MSG_MS = 2000;
    localparam int SHORT_DISP_MS = 2000;
    localparam int SINGLE_DISP_MS = 28000;
    localparam int MULTI_SHORT_MS = 5000;
    localparam int MULTI_LONG_MS = 28000;
    localparam int DEBOUNCE_MS = 20;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * MS_CYCLES;
    // Mode encodings
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_ENDLESS = 2'h1;
    localparam logic [1:0] MODE_MULTI = 2'h2;
    localparam int MULTI_COUNT = 5;
    localparam int MULTI_FOUND_FACTOR = 2;
    typedef enum logic [2:0] {
        APS_BOOT = 3'b000,
        APS_MEAS = 3'b001,
        APS_WAIT = 3'b010,
        APS_DISP = 3'b011,
        APS_OFF = 3'b100
    } aps_state_e;
endpackage

//--- verilog/aps_sequencer.sv
`timescale 1ns/100ps
// Function
// - Assert power hold as the first action after reset release.
// - Internal key pull-up kept off; board supplies external pull-up.
// - Key still pressed after measurement: drop hold after short display.
// - Start message shown, result presented about two seconds later.
// - Single mode: power off after result displayed the long period.
// - Key press during display aborts it and starts a new measurement.
// - Endless mode: repeat measurements forever, never drop power hold.
// - Multi mode: power off after N consecutive no-part results.
// - Multi mode: power off after 2N consecutive found-part results.
// - A found result clears the miss counter; a miss clears found.
// - Multi mode: short power-on press gives 5 s, held press 28 s.
// - Without shutdown circuit, last result stays until next key press.
module aps_sequencer
    import aps_pkg::*;
#(
    parameter logic [1:0] MODE = MODE_SINGLE,
    parameter int COUNT_N = MULTI_COUNT,
    parameter bit HAS_SHUTDOWN = 1'b1,
    parameter int MS_CYC = MS_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic start_key_input_n,
    input wire logic meas_done,
    input wire logic meas_part_found,
    output logic power_hold_output,
    output logic key_pullup_en,
    output logic start_msg,
    output logic meas_start,
    output logic result_show,
    output logic [2:0] seq_state
);

    // ----------------------------------------------------------------
    // Reset synchroniser
    // ----------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_ff;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire rst_n = rst_sync_ff;

    // ----------------------------------------------------------------
    // Millisecond tick
    // ----------------------------------------------------------------
    logic [31:0] div_ff;
    wire ms_tick = (div_ff == 32'(MS_CYC - 1));
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 32'h0;
        end else begin
            div_ff <= ms_tick ? 32'h0 : div_ff + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // Key debounce (key is active low; released reads high)
    // ----------------------------------------------------------------
    logic [15:0] deb_ff;
    logic key_ff;
    logic key_prev_ff;
    wire key_raw = ~start_key_input_n;
    wire deb_done = (deb_ff == 16'(DEBOUNCE_MS));
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            deb_ff <= 16'h0;
            key_ff <= 1'b0;
            key_prev_ff <= 1'b0;
        end else begin
            key_prev_ff <= key_ff;
            if (key_raw == key_ff) begin
                deb_ff <= 16'h0;
            end else if (ms_tick) begin
                deb_ff <= deb_done ? 16'h0 : deb_ff + 16'h1;
                if (deb_done) begin
                    key_ff <= key_raw;
                end
            end
        end
    end
    wire key_press = key_ff & ~key_prev_ff;

    // ----------------------------------------------------------------
    // Power-on press classification
    // ----------------------------------------------------------------
    // Held through the start message means the long display period
    logic long_disp_ff;
    logic first_ff;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    aps_state_e state_ff;
    aps_state_e nxt_state;
    logic [15:0] ms_cnt_ff;
    logic [7:0] miss_cnt_ff;
    logic [7:0] hit_cnt_ff;
    logic [7:0] nxt_miss;
    logic [7:0] nxt_hit;
    logic key_at_done_ff;

    wire auto_off = HAS_SHUTDOWN && (MODE != MODE_ENDLESS);
    wire [15:0] disp_ms =
        key_at_done_ff ? 16'(SHORT_DISP_MS) :
        (MODE == MODE_MULTI) ?
            (long_disp_ff ? 16'(MULTI_LONG_MS)
                          : 16'(MULTI_SHORT_MS)) :
        16'(SINGLE_DISP_MS);
    wire disp_over = ms_tick && (ms_cnt_ff >= disp_ms - 16'h1);
    wire msg_over = ms_tick && (ms_cnt_ff >= 16'(START_MSG_MS - 1));
    wire miss_lim = (nxt_miss >= 8'(COUNT_N));
    wire hit_lim =
        (nxt_hit >= 8'(COUNT_N * MULTI_FOUND_FACTOR));

    always_comb begin
        nxt_miss = miss_cnt_ff;
        nxt_hit = hit_cnt_ff;
        if (meas_done) begin
            if (meas_part_found) begin
                nxt_hit = hit_cnt_ff + 8'h1;
                nxt_miss = 8'h0;
            end else begin
                nxt_miss = miss_cnt_ff + 8'h1;
                nxt_hit = 8'h0;
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            APS_BOOT: begin
                nxt_state = APS_MEAS;
            end
            APS_MEAS: begin
                if (msg_over) begin
                    nxt_state = APS_WAIT;
                end
            end
            APS_WAIT: begin
                if (meas_done) begin
                    if (MODE == MODE_ENDLESS) begin
                        nxt_state = APS_MEAS;
                    end else if (MODE == MODE_MULTI && auto_off &&
                                 !key_ff && (miss_lim || hit_lim)) begin
                        nxt_state = APS_OFF;
                    end else begin
                        nxt_state = APS_DISP;
                    end
                end
            end
            APS_DISP: begin
                if (key_press) begin
                    nxt_state = APS_MEAS;
                end else if (!auto_off) begin
                    nxt_state = APS_DISP;
                end else if (disp_over) begin
                    nxt_state = (MODE == MODE_MULTI && !key_at_done_ff)
                                ? APS_MEAS : APS_OFF;
                end
            end
            APS_OFF: begin
                nxt_state = APS_OFF;
            end
            default: begin
                nxt_state = APS_OFF;
            end
        endcase
    end

    wire entering = (nxt_state != state_ff);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= APS_BOOT;
            ms_cnt_ff <= 16'h0;
            miss_cnt_ff <= 8'h0;
            hit_cnt_ff <= 8'h0;
            key_at_done_ff <= 1'b0;
            long_disp_ff <= 1'b0;
            first_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            if (entering) begin
                ms_cnt_ff <= 16'h0;
            end else if (ms_tick && ms_cnt_ff != 16'hffff) begin
                ms_cnt_ff <= ms_cnt_ff + 16'h1;
            end
            miss_cnt_ff <= nxt_miss;
            hit_cnt_ff <= nxt_hit;
            if (state_ff == APS_WAIT && meas_done) begin
                key_at_done_ff <= key_ff && auto_off;
            end
            if (first_ff && state_ff == APS_MEAS && msg_over) begin
                long_disp_ff <= key_ff;
                first_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            power_hold_output <= 1'b0;
            key_pullup_en <= 1'b0;
            start_msg <= 1'b0;
            meas_start <= 1'b0;
            result_show <= 1'b0;
            seq_state <= 3'h0;
        end else begin
            // Hold goes high first cycle out of reset, low only in off
            power_hold_output <= (nxt_state != APS_OFF);
            key_pullup_en <= 1'b0;
            start_msg <= (nxt_state == APS_MEAS);
            meas_start <= (state_ff == APS_MEAS) && msg_over;
            result_show <= (nxt_state == APS_DISP);
            seq_state <= 3'(nxt_state);
        end
    end

endmodule

//--- sim/aps_partner.sv
`timescale 1ns/100ps
module aps_partner (
    input wire logic mclk,
    input wire logic key_press,
    input wire logic power_hold_output,
    input wire logic meas_start,
    output logic start_key_input_n,
    output logic supply_on,
    output logic meas_done
);
    logic [2:0] dly_ff = 3'h0;
    // External pull-up: released key reads high
    assign start_key_input_n = !key_press;
    // Key bridges the switch until hold latches it
    assign supply_on = key_press | power_hold_output;
    assign meas_done = (dly_ff == 3'h1);
    always_ff @(posedge mclk) begin
        if (meas_start)
            dly_ff <= 3'h5;
        else if (dly_ff != 3'h0)
            dly_ff <= dly_ff - 3'h1;
    end
endmodule

//--- sim/aps_checker.sv
`timescale 1ns/100ps
module aps_checker
    import aps_pkg::*;
#(
    parameter logic [1:0] MODE = MODE_SINGLE,
    parameter int MS_CYC = MS_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic start_key_input_n,
    input wire logic meas_done,
    input wire logic power_hold_output,
    input wire logic key_pullup_en,
    input wire logic start_msg,
    input wire logic meas_start,
    input wire logic result_show,
    input wire logic [2:0] seq_state
);
    int msg_n_ff, show_n_ff;
    // Allow for the ms tick phase
    function automatic bit near(int n, int ms);
        return n >= (ms - 2) * MS_CYC && n <= (ms + 2) * MS_CYC;
    endfunction
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            msg_n_ff <= 0;
            show_n_ff <= 0;
        end else begin
            msg_n_ff <= start_msg ? msg_n_ff + 1 : result_show ? 0 : msg_n_ff;
            show_n_ff <= result_show ? show_n_ff + 1 : start_msg ? 0 : show_n_ff;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    AST_PULLUP_OFF: assert property (!key_pullup_en)
        else $error("pull-up on");
    AST_HOLD_IN_MSG: assert property (start_msg |-> power_hold_output)
        else $error("hold low in message");
    AST_MSG_LEN: assert property (meas_start |-> near(msg_n_ff, 2000))
        else $error("message length");
    AST_START_PULSE: assert property (meas_start |=> !meas_start)
        else $error("start not a pulse");
    AST_SHOW: assert property (meas_done && seq_state == 3'h2
        |=> result_show && seq_state == 3'h3) else $error("no result");
    AST_DISP_LEN: assert property (MODE == MODE_SINGLE
        && $fell(power_hold_output) |-> near(show_n_ff, 2000)
        || near(show_n_ff, 28000)) else $error("display length");
    AST_OFF: assert property (seq_state == 3'h4 |-> !power_hold_output)
        else $error("hold in off");
    AST_ABORT: assert property (MODE == MODE_SINGLE && $rose(start_msg)
        && $past(result_show) |-> !$past(start_key_input_n))
        else $error("restart without key");
    AST_ENDLESS: assert property (MODE == MODE_ENDLESS
        && power_hold_output |=> power_hold_output) else $error("endless off");
endmodule
bind aps_sequencer aps_checker #(.MODE(MODE), .MS_CYC(MS_CYC)) u_chk (
    .mclk(mclk), .nrst(nrst), .start_key_input_n(start_key_input_n),
    .meas_done(meas_done), .power_hold_output(power_hold_output),
    .key_pullup_en(key_pullup_en), .start_msg(start_msg),
    .meas_start(meas_start), .result_show(result_show),
    .seq_state(seq_state));

//--- sim/auto_power_off_sequencer_bench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    fail_count++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module auto_power_off_sequencer_bench;
    import aps_pkg::*;
    logic mclk, nrst, key_press, k_n, done, hold, pu, msg, mst, show, sup;
    logic [2:0] st;
    int fail_count = 0, checks_done = 0, cyc = 0, t0;
    aps_sequencer #(.MODE(MODE_SINGLE), .MS_CYC(1)) u_aps_sequencer (
        .mclk(mclk), .nrst(nrst), .start_key_input_n(k_n), .meas_done(done),
        .meas_part_found(1'b1), .power_hold_output(hold), .key_pullup_en(pu),
        .start_msg(msg), .meas_start(mst), .result_show(show), .seq_state(st));
    aps_partner u_aps_partner (.mclk(mclk), .key_press(key_press),
        .power_hold_output(hold), .meas_start(mst), .supply_on(sup),
        .start_key_input_n(k_n), .meas_done(done));
    initial begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    // Hang guard, two scenarios need about 36k cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 50000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic t_single();
        nrst = 0;
        key_press = 1;
        tick(6);
        nrst = 1;
        t0 = cyc;
        tick(5);
        key_press = 0;
        tick(1);
        `CHK("supply", 1'b1, sup)
        `CHK("pullup", 1'b0, pu)
        `CHK("start_msg", 1'b1, msg)
        while (mst !== 1'b1) tick(1);
        `CHK("msg time", 1'b1, (cyc - t0) inside {[2000:2006]})
        while (show !== 1'b1) tick(1);
        t0 = cyc;
        while (hold !== 1'b0) tick(1);
        `CHK("disp time", 1'b1, (cyc - t0) inside {[27998:28003]})
        `CHK("state", 3'h4, st)
    endtask
    // Key held through the restart, so the next result times out short
    task automatic t_abort_held();
        nrst = 0;
        tick(6);
        nrst = 1;
        while (show !== 1'b1) tick(1);
        key_press = 1;
        tick(40);
        `CHK("restart", 1'b1, msg)
        `CHK("hold kept", 1'b1, hold)
        while (show !== 1'b1) tick(1);
        t0 = cyc;
        while (hold !== 1'b0) tick(1);
        key_press = 0;
        `CHK("short disp", 1'b1, (cyc - t0) inside {[1998:2003]})
    endtask
    initial begin
        nrst = 0;
        key_press = 0;
        @(posedge mclk);
        #1;
        t_single();
        t_abort_held();
        report_and_stop();
    end
endmodule
